//--- mode_bank_cfg.svh
// constants for the mode register state bank
//
// Operation
// - each mode change forces, keeps or tracks every bit per mode
// - entering Off loads all bits with reset values
// - undervoltage sleep clears events and selective wake, sets bus and wake input wake enables, flag, code 001
// - a mode change discards the held byte and the rest of any serial access in progress
// - mode code reads 100 standby, 111 normal, 001 sleep
// - live status tracked in every mode; transmitter active only in Normal
// - event summary at 0x60 backed by event registers at 0x61, 0x63, 0x64
// - identification register at 0x7e, fixed, unaffected by mode
// - access starts with 7-bit address then read flag, then one to three bytes
// - writes not 16, 24 or 32 bits drop the held byte and raise serial fault
`ifndef MODE_BANK_CFG_SVH
`define MODE_BANK_CFG_SVH
`define ADDR_MODE_CTRL 7'h01
`define ADDR_MAIN_STAT 7'h03
`define ADDR_BUS_CTRL 7'h20
`define ADDR_TRX_STAT 7'h22
`define ADDR_TRX_EN 7'h23
`define ADDR_RATE 7'h26
`define ADDR_FRAME 7'h2f
`define ADDR_WAKE_EN 7'h4c
`define ADDR_EVT_SUM 7'h60
`define ADDR_SYS_EVT 7'h61
`define ADDR_TRX_EVT 7'h63
`define ADDR_WAKE_EVT 7'h64
`define ADDR_IDENT 7'h7e
`define MC_STANDBY 3'h4
`define MC_NORMAL 3'h7
`define MC_SLEEP 3'h1
`define RST_RATE 3'h5
`define SYS_MASK 8'h16
`define TRX_MASK 8'h23
`define WAKE_MASK 8'h03
`endif

//--- mode_bank_pkg.sv
// types for the mode register state bank
package mode_bank_pkg;
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_STANDBY = 3'b001,
    MODE_NORMAL = 3'b010,
    MODE_SLEEP = 3'b011,
    MODE_OVERTEMP = 3'b100,
    MODE_UVSLEEP = 3'b101
  } op_mode_e;
  typedef struct packed {
    logic busSilent;
    logic oscillator;
    logic supplyUnder;
    logic selectiveErr;
    logic selectiveOk;
    logic overheatWarn;
    logic busFailure;
    logic txActive;
  } live_status_s;
  typedef struct packed {
    logic overheatWarn;
    logic busWake;
    logic busFailure;
    logic fdFrameError;
    logic wakeRise;
    logic wakeFall;
  } event_in_s;
endpackage : mode_bank_pkg

//--- mode_register_state_bank.sv
// register bank with mode driven state changes and spi slave
`timescale 1ns/1ps
`include "mode_bank_cfg.svh"
module mode_register_state_bank
  import mode_bank_pkg::*;
#(
  parameter logic [7:0] IDENT_CODE = 8'h5a  // value is arbitrary
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic modeChange,
  input op_mode_e newMode,
  input live_status_s liveStatus,
  input event_in_s eventIn,
  input wire logic csN,
  input wire logic sck,
  input wire logic sdi,
  output logic sdo,
  output op_mode_e modeState
);
  // ==========================================================
  // serial framing, sck sampled as synchronous input
  logic sckQ_ff;
  logic csQ_ff;
  logic [5:0] bitCnt_ff;
  logic [7:0] shIn_ff;
  logic [7:0] shOut_ff;
  logic [6:0] addr_ff;
  logic rdFlag_ff;
  logic abort_ff;
  logic [7:0] pend_ff;
  logic [6:0] pendAddr_ff;
  logic [1:0] pendCnt_ff;
  wire sckRise = sckQ_ff == 1'b0 && sck == 1'b1 && !csN;
  wire sckFall = sckQ_ff == 1'b1 && sck == 1'b0 && !csN;
  wire csEnd = csQ_ff == 1'b0 && csN == 1'b1;
  wire [7:0] byteIn = {shIn_ff[6:0], sdi};
  wire byteDone = sckRise && bitCnt_ff[2:0] == 3'h7;
  wire hdrDone = byteDone && bitCnt_ff[5:3] == 3'h0;
  wire dataDone = byteDone && bitCnt_ff[5:3] != 3'h0
    && bitCnt_ff[5:3] < 3'h4;
  wire [6:0] curAddr = hdrDone ? byteIn[7:1] : addr_ff;
  wire lenOk = bitCnt_ff == 6'd16 || bitCnt_ff == 6'd24
    || bitCnt_ff == 6'd32;
  wire commit = csEnd && !rdFlag_ff && !abort_ff && !modeChange
    && lenOk;
  wire spiFault = csEnd && !rdFlag_ff && !abort_ff && !modeChange
    && !lenOk && bitCnt_ff != 6'd0;
  // ==========================================================
  // register state
  logic [2:0] modeCode_ff;
  logic normalEntered_ff;
  logic uvSleepFlag_ff;
  logic selWakeEn_ff;
  logic selCfgValid_ff;
  logic busWakeEn_ff;
  logic busFailEn_ff;
  logic [2:0] bitRate_ff;
  logic payloadMatch_ff;
  logic wakeRiseEn_ff;
  logic wakeFallEn_ff;
  logic [7:0] sysEvt_ff;
  logic [7:0] trxEvt_ff;
  logic [7:0] wakeEvt_ff;
  logic [7:0] nxt_sysEvt;
  logic [7:0] nxt_trxEvt;
  logic [7:0] nxt_wakeEvt;
  logic systemSummary_ff;
  logic transceiverSummary_ff;
  logic wakeInputSummary_ff;
  wire txLive = modeState == MODE_NORMAL && liveStatus.txActive;
  function automatic logic [7:0] rd(input logic [6:0] a);
    if (a == `ADDR_MODE_CTRL) rd = {5'h00, modeCode_ff};
    else if (a == `ADDR_MAIN_STAT)
      rd = {uvSleepFlag_ff, liveStatus.overheatWarn, normalEntered_ff, 5'h00};
    else if (a == `ADDR_BUS_CTRL)
      rd = {2'h0, selCfgValid_ff, selWakeEn_ff, 4'h0};
    else if (a == `ADDR_TRX_STAT)
      rd = {txLive, liveStatus.selectiveErr, liveStatus.selectiveOk,
            liveStatus.oscillator, liveStatus.busSilent, 1'b0,
            liveStatus.supplyUnder, liveStatus.busFailure};
    else if (a == `ADDR_TRX_EN) rd = {6'h00, busFailEn_ff, busWakeEn_ff};
    else if (a == `ADDR_RATE) rd = {5'h00, bitRate_ff};
    else if (a == `ADDR_FRAME) rd = {1'b0, payloadMatch_ff, 6'h00};
    else if (a == `ADDR_WAKE_EN) rd = {6'h00, wakeRiseEn_ff, wakeFallEn_ff};
    else if (a == `ADDR_EVT_SUM)
      rd = {4'h0, wakeInputSummary_ff, transceiverSummary_ff, 1'b0,
            systemSummary_ff};
    else if (a == `ADDR_SYS_EVT) rd = sysEvt_ff & `SYS_MASK;
    else if (a == `ADDR_TRX_EVT) rd = trxEvt_ff & `TRX_MASK;
    else if (a == `ADDR_WAKE_EVT) rd = wakeEvt_ff & `WAKE_MASK;
    else if (a == `ADDR_IDENT) rd = IDENT_CODE;
    else rd = 8'h00;
  endfunction : rd
  wire [6:0] nextAddr = curAddr + 7'h01;
  // next byte appears after the fall that ends a byte, ready for next rise
  wire loadOut = sckFall && bitCnt_ff[2:0] == 3'h0
    && bitCnt_ff[5:3] != 3'h0 && bitCnt_ff[5:3] < 3'h4;
  wire [7:0] rdData = rd(addr_ff);
  wire wrEn = commit && pendCnt_ff != 2'h0;
  // pending bytes: only the last byte is held; earlier ones are applied
  wire applyNow = dataDone && !rdFlag_ff && !abort_ff && !modeChange
    && bitCnt_ff[5:3] > 3'h1;
  wire doWr = wrEn || applyNow;
  wire [6:0] wA = pendAddr_ff;
  wire [7:0] wD = pend_ff;
  wire isSys = doWr && wA == `ADDR_SYS_EVT;
  wire isTrx = doWr && wA == `ADDR_TRX_EVT;
  wire isWake = doWr && wA == `ADDR_WAKE_EVT;
  wire [7:0] sysSet = {3'h0, 1'b0, 1'b0, eventIn.overheatWarn, spiFault, 1'b0};
  wire [7:0] trxSet = {2'h0, eventIn.fdFrameError, 3'h0, eventIn.busFailure,
                       eventIn.busWake};
  wire [7:0] wakeSet = {6'h00, eventIn.wakeRise, eventIn.wakeFall};
  always_comb begin
    // set wins over write-one-to-clear
    nxt_sysEvt = ((sysEvt_ff & ~(isSys ? wD : 8'h00)) | sysSet) & `SYS_MASK;
    nxt_trxEvt = ((trxEvt_ff & ~(isTrx ? wD : 8'h00)) | trxSet) & `TRX_MASK;
    nxt_wakeEvt = ((wakeEvt_ff & ~(isWake ? wD : 8'h00)) | wakeSet)
      & `WAKE_MASK;
  end
  // ==========================================================
  // serial engine
  always_ff @(posedge clk) begin
    sckQ_ff <= sck;
    csQ_ff <= csN;
    if (reset || csN || modeChange) begin
      bitCnt_ff <= 6'd0;
      abort_ff <= modeChange && !csN;
      pendCnt_ff <= 2'h0;
      rdFlag_ff <= 1'b0;
      if (reset) begin
        shIn_ff <= 8'h00;
        shOut_ff <= 8'h00;
        addr_ff <= 7'h00;
        pend_ff <= 8'h00;
        pendAddr_ff <= 7'h00;
        abort_ff <= 1'b0;
      end
    end else begin
      if (csQ_ff && !csN) abort_ff <= 1'b0;
      if (sckRise) begin
        shIn_ff <= byteIn;
        if (bitCnt_ff != 6'd63) bitCnt_ff <= bitCnt_ff + 6'd1;
      end
      if (hdrDone) begin
        addr_ff <= byteIn[7:1];
        rdFlag_ff <= byteIn[0];
      end
      if (dataDone) begin
        pend_ff <= byteIn;
        pendAddr_ff <= addr_ff;
        addr_ff <= nextAddr;
        pendCnt_ff <= 2'h1;
      end
      if (loadOut) shOut_ff <= rdData;
      else if (sckFall) shOut_ff <= {shOut_ff[6:0], 1'b0};
    end
  end
  assign sdo = csN ? 1'b0 : shOut_ff[7];
  // ==========================================================
  // mode driven register updates
  always_ff @(posedge clk) begin
    systemSummary_ff <= |(nxt_sysEvt);
    transceiverSummary_ff <= |(nxt_trxEvt);
    wakeInputSummary_ff <= |(nxt_wakeEvt);
    sysEvt_ff <= nxt_sysEvt;
    trxEvt_ff <= nxt_trxEvt;
    wakeEvt_ff <= nxt_wakeEvt;
    if (reset || (modeChange && newMode == MODE_OFF)) begin
      modeState <= MODE_OFF;
      modeCode_ff <= `MC_STANDBY;
      normalEntered_ff <= 1'b1;
      uvSleepFlag_ff <= 1'b0;
      selWakeEn_ff <= 1'b0;
      selCfgValid_ff <= 1'b0;
      busWakeEn_ff <= 1'b0;
      busFailEn_ff <= 1'b0;
      bitRate_ff <= `RST_RATE;
      payloadMatch_ff <= 1'b1;
      wakeRiseEn_ff <= 1'b0;
      wakeFallEn_ff <= 1'b0;
      sysEvt_ff <= 8'h10;
      trxEvt_ff <= 8'h00;
      wakeEvt_ff <= 8'h00;
      systemSummary_ff <= 1'b1;
      transceiverSummary_ff <= 1'b0;
      wakeInputSummary_ff <= 1'b0;
    end else if (modeChange) begin
      modeState <= newMode;
      case (newMode)
        MODE_STANDBY: modeCode_ff <= `MC_STANDBY;
        MODE_NORMAL: begin
          modeCode_ff <= `MC_NORMAL;
          normalEntered_ff <= 1'b0;
        end
        MODE_SLEEP: begin
          modeCode_ff <= `MC_SLEEP;
          uvSleepFlag_ff <= 1'b0;
        end
        MODE_UVSLEEP: begin
          modeCode_ff <= `MC_SLEEP;
          uvSleepFlag_ff <= 1'b1;
          busWakeEn_ff <= 1'b1;
          wakeRiseEn_ff <= 1'b1;
          wakeFallEn_ff <= 1'b1;
          selWakeEn_ff <= 1'b0;
          selCfgValid_ff <= 1'b0;
          sysEvt_ff <= 8'h00;
          trxEvt_ff <= 8'h00;
          wakeEvt_ff <= 8'h00;
          systemSummary_ff <= 1'b0;
          transceiverSummary_ff <= 1'b0;
          wakeInputSummary_ff <= 1'b0;
        end
        default: modeCode_ff <= modeCode_ff;
      endcase
    end else if (doWr) begin
      if (wA == `ADDR_MODE_CTRL &&
          (wD[2:0] == `MC_STANDBY || wD[2:0] == `MC_NORMAL
           || wD[2:0] == `MC_SLEEP))
        modeCode_ff <= wD[2:0];
      else if (wA == `ADDR_BUS_CTRL) begin
        selCfgValid_ff <= wD[5];
        selWakeEn_ff <= wD[4];
      end else if (wA == `ADDR_TRX_EN) begin
        busFailEn_ff <= wD[1];
        busWakeEn_ff <= wD[0];
      end else if (wA == `ADDR_RATE) bitRate_ff <= wD[2:0];
      else if (wA == `ADDR_FRAME) payloadMatch_ff <= wD[6];
      else if (wA == `ADDR_WAKE_EN) begin
        wakeRiseEn_ff <= wD[1];
        wakeFallEn_ff <= wD[0];
      end
    end
  end
endmodule : mode_register_state_bank

//--- mode_bank_chk.sv
// assertion checker for the mode register state bank
`timescale 1ns/1ps
module mode_bank_chk
  import mode_bank_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic modeChange,
  input op_mode_e newMode,
  input wire logic csN,
  input wire logic sdo,
  input op_mode_e modeState
);
  // =====
  // mode tracking and serial idle checks
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_mode_follows: assert property (modeChange |=> modeState == $past(newMode))
    else $error("mode not taken");
  a_mode_holds: assert property (!modeChange |=> $stable(modeState))
    else $error("mode moved alone");
  a_mode_persists: assert property (modeChange ##1 !modeChange
    |=> modeState == $past(newMode, 2)) else $error("mode not kept");
  a_reset_off: assert property (disable iff (1'b0)
    reset |=> modeState == MODE_OFF) else $error("reset not off");
  a_release_off: assert property ($fell(reset) |-> modeState == MODE_OFF)
    else $error("off lost at release");
  a_off_entry: assert property (modeChange && newMode == MODE_OFF
    |=> modeState == MODE_OFF) else $error("off not entered");
  a_mode_legal: assert property (modeState inside {MODE_OFF, MODE_STANDBY,
    MODE_NORMAL, MODE_SLEEP, MODE_OVERTEMP, MODE_UVSLEEP})
    else $error("illegal mode");
  a_sdo_idle: assert property (csN && $past(csN) |-> !sdo)
    else $error("sdo active while idle");
endmodule : mode_bank_chk
bind mode_register_state_bank mode_bank_chk chk_u (.clk(clk),
  .reset(reset), .modeChange(modeChange), .newMode(newMode),
  .csN(csN), .sdo(sdo), .modeState(modeState));

//--- spi_host_model.sv
// serial host model for the register port
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk,
  output logic csN,
  output logic sck,
  output logic sdi,
  input wire logic sdo
);
  // =====
  // framing, msb first, clock idles low
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic xfer(input int nBits, input logic [31:0] w,
                      output logic [31:0] got);
    got = '0;
    tick(1);
    csN = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      sdi = w[31-i];
      tick(3);
      got = {got[30:0], sdo};
      sck = 1'b1;
      tick(3);
      sck = 1'b0;
    end
    tick(3);
    csN = 1'b1;
    sdi = ~sdi;
    tick(3);
  endtask : xfer
endmodule : spi_host_model

//--- tb_top.sv
// testbench for the mode register state bank
`timescale 1ns/1ps
module tb_top
  import mode_bank_pkg::*;
;
  logic clk, reset, modeChange, csN, sck, sdi, sdo;
  op_mode_e newMode, modeState;
  live_status_s liveStatus;
  event_in_s eventIn;
  int miscompares, total_checks;
  mode_register_state_bank dut_u (.clk(clk), .reset(reset),
    .modeChange(modeChange), .newMode(newMode), .liveStatus(liveStatus),
    .eventIn(eventIn), .csN(csN), .sck(sck), .sdi(sdi), .sdo(sdo),
    .modeState(modeState));
  spi_host_model hostU (.clk(clk), .csN(csN), .sck(sck), .sdi(sdi),
    .sdo(sdo));
  // =====
  // helpers
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic cmp(input logic [6:0] a, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED reg %h expected %h seen %h", a, e, g);
    end
  endtask : cmp
  task automatic rd(input int n, input logic [6:0] a, input logic [31:0] e);
    logic [31:0] g;
    hostU.xfer(n, {a, 1'b1, 24'h0}, g);
    cmp(a, e, g & ((32'h1 << (n - 8)) - 32'h1));
  endtask : rd
  task automatic wr(input int n, input logic [31:0] w);
    logic [31:0] g;
    hostU.xfer(n, w, g);
  endtask : wr
  task automatic go(input op_mode_e m);
    hostU.tick(1);
    modeChange = 1'b1;
    newMode = m;
    hostU.tick(1);
    modeChange = 1'b0;
  endtask : go
  // =====
  // scenarios
  task automatic test_reset();
    rd(32, 7'h60, 32'h011000);
    rd(32, 7'h63, 32'h000000);
    rd(16, 7'h7e, 32'h5a);
    rd(16, 7'h26, 32'h05);
    rd(16, 7'h2f, 32'h40);
    rd(24, 7'h01, 32'h0400);
    $display("reset values done");
  endtask : test_reset
  task automatic test_modes();
    op_mode_e m[3] = '{MODE_STANDBY, MODE_NORMAL, MODE_SLEEP};
    logic [23:0] st[3] = '{24'h040060, 24'h070040, 24'h010000};
    logic [7:0] tx[3] = '{8'h7b, 8'hd0, 8'h2b};
    live_status_s ls[3] = '{8'hff, 8'h55, 8'haa};
    for (int i = 0; i < 3; i++) begin
      liveStatus = ls[i];
      go(m[i]);
      rd(32, 7'h01, {8'h0, st[i]});
      rd(16, 7'h22, {24'h0, tx[i]});
    end
    $display("mode codes done");
  endtask : test_modes
  task automatic test_events();
    eventIn = 6'h2a;
    hostU.tick(2);
    eventIn = '0;
    wr(16, {7'h61, 1'b0, 8'h10, 16'h0});
    wr(12, {7'h61, 1'b0, 4'hf, 20'h0});
    rd(32, 7'h61, 32'h060002);
    rd(16, 7'h60, 32'h0d);
    rd(16, 7'h64, 32'h02);
    wr(32, {7'h61, 1'b0, 8'h06, 8'h00, 8'h02});
    wr(16, {7'h64, 1'b0, 8'h02, 16'h0});
    rd(16, 7'h60, 32'h00);
    eventIn = 6'h15;
    hostU.tick(2);
    eventIn = '0;
    rd(32, 7'h63, 32'h210100);
    rd(16, 7'h60, 32'h0c);
    $display("events done");
  endtask : test_events
  task automatic test_abort();
    fork
      wr(16, {7'h26, 1'b0, 8'h02, 16'h0});
      begin
        hostU.tick(60);
        go(MODE_STANDBY);
      end
    join
    rd(16, 7'h26, 32'h05);
    rd(16, 7'h01, 32'h04);
    $display("abort done");
  endtask : test_abort
  task automatic test_uv();
    wr(16, {7'h20, 1'b0, 8'h30, 16'h0});
    wr(16, {7'h23, 1'b0, 8'h02, 16'h0});
    rd(16, 7'h20, 32'h30);
    rd(16, 7'h23, 32'h02);
    go(MODE_UVSLEEP);
    rd(32, 7'h60, 32'h0);
    rd(24, 7'h63, 32'h0);
    rd(32, 7'h01, 32'h010080);
    rd(16, 7'h4c, 32'h03);
    rd(16, 7'h23, 32'h03);
    rd(16, 7'h20, 32'h00);
    $display("undervoltage sleep done");
  endtask : test_uv
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    reset = 1'b1;
    modeChange = 1'b0;
    newMode = MODE_OFF;
    liveStatus = '0;
    eventIn = '0;
    miscompares = 0;
    total_checks = 0;
    hostU.tick(12);
    reset = 1'b0;
    hostU.tick(1);
    test_reset();
    test_modes();
    test_events();
    test_abort();
    test_uv();
    go(MODE_OFF);
    test_reset();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end
endmodule : tb_top
